//--- unlock_tick_div.sv
package flash_unlock_pkg;
	// clock and oscillator rates
	localparam int CLK_HZ = 125000000;
	localparam int OSC_HZ = 32000;
	localparam int OSC_DIV = CLK_HZ / OSC_HZ;
	// unlock window length, rounded down to whole oscillator ticks
	localparam int TIMEOUT_US = 300;
	localparam int TIMEOUT_TICKS = TIMEOUT_US * OSC_HZ / 1000000;
	localparam int TICK_W = 8;
	// mode code and pattern words (low byte written first)
	localparam logic [2:0] MODE_WRITE_UNLOCK = 3'h6;
	localparam logic [15:0] PATTERN_WORD1 = 16'h0400;
	localparam logic [15:0] PATTERN_WORD2 = 16'h090D;
	localparam logic [15:0] PATTERN_WORD3 = 16'h40C3;
	localparam int DATA_WORDS = 4;
	localparam int ADDR_HIGH_W_SMALL = 6;
	localparam int ADDR_LOW_PAGE_MSB = 7;
	localparam int ADDR_LOW_PAGE_LSB = 6;

	// one byte write into the data word registers
	typedef struct packed {
		logic en;
		logic [2:0] sel;
		logic [7:0] value;
	} data_wr_s;

	// control register write: mode and arm bit arrive together
	typedef struct packed {
		logic en;
		logic [2:0] mode;
		logic arm;
	} ctrl_wr_s;

	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CHECK} unlock_state_e;
endpackage

`timescale 1ns/1ns

module unlock_tick_div #(
	parameter int DIV = flash_unlock_pkg::OSC_DIV
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	output logic tick
);
	import flash_unlock_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} div_state_s;

	div_state_s st_reg;
	div_state_s st_next;

	// free-running divider, one-cycle enable per oscillator period
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.cnt == 16'(DIV - 1)) begin
			st_next.cnt = 16'h0000;
			st_next.tick = 1'b1;
		end else begin
			st_next.cnt = st_reg.cnt + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick = st_reg.tick;

	tick_period_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		tick |=> !tick) else $error("divider tick lasted more than one cycle");
endmodule // unlock_tick_div

//--- flash_write_unlock_sequencer.sv
`timescale 1ns/1ns

// Contract
// - mode select code 110 chooses the write-unlock mode
// - arm bit and mode code are accepted in one control write
// - arming starts a 300 us timeout counted on the slow oscillator tick; the code ends it on the 9th tick, at most 281.25 us
// - at overflow the arm bit clears, then the pattern is compared
// - a matching pattern sets the write-enabled flag
// - software may clear the flag, blocking erase and write until unlocked again
// - erase page is high address with low bits 7..6; bits 5..0 ignored
// - page width gives 256 or 512 pages by variant
// - processor halts while write or read initiate is set
// - hardware clears write initiate when the flash write finishes
module flash_write_unlock_sequencer #(
	parameter int ADDR_HIGH_W = flash_unlock_pkg::ADDR_HIGH_W_SMALL,
	parameter int OSC_DIV = flash_unlock_pkg::OSC_DIV,
	parameter int TIMEOUT_TICKS = flash_unlock_pkg::TIMEOUT_TICKS
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire flash_unlock_pkg::ctrl_wr_s ctrl_wr,
	input wire flash_unlock_pkg::data_wr_s data_wr,
	input wire logic flag_clear,
	input wire logic write_init_set,
	input wire logic read_init_set,
	input wire logic erase_req,
	input wire logic flash_done,
	input wire logic [7:0] flash_addr_low,
	input wire logic [ADDR_HIGH_W-1:0] flash_addr_high,
	output logic [2:0] flash_mode_select,
	output logic unlock_arm_bit,
	output logic write_enabled_flag,
	output logic write_initiate_bit,
	output logic read_initiate_bit,
	output logic cpu_halt,
	output logic erase_go,
	output logic [ADDR_HIGH_W+1:0] erase_page,
	output logic [63:0] data_words
);
	import flash_unlock_pkg::*;

	typedef struct packed {
		unlock_state_e fsm;
		logic [2:0] mode;
		logic arm;
		logic wen;
		logic wt;
		logic rd;
		logic [TICK_W-1:0] ticks;
		logic [DATA_WORDS-1:0][15:0] data;
		logic erase_go;
		logic [ADDR_HIGH_W+1:0] page;
	} seq_state_s;

	seq_state_s st_reg;
	seq_state_s st_next;
	logic slow_tick;
	logic pattern_match;
	logic arm_request;
	logic timeout_hit;

	unlock_tick_div #(
		.DIV(OSC_DIV)
	) u_tick_div (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.tick(slow_tick)
	);

	// pattern compare on data words one to three
	// expected pattern words
	assign pattern_match = (st_reg.data[1] == PATTERN_WORD1) &&
		(st_reg.data[2] == PATTERN_WORD2) && (st_reg.data[3] == PATTERN_WORD3);
	assign arm_request = ctrl_wr.en && ctrl_wr.arm && (ctrl_wr.mode == MODE_WRITE_UNLOCK);
	// window ends on the last slow tick counted since arming
	assign timeout_hit = slow_tick && (st_reg.ticks == TICK_W'(TIMEOUT_TICKS - 1));

	// next-state logic for the whole sequencer
	always_comb begin
		st_next = st_reg;
		st_next.erase_go = 1'b0;
		// data byte writes, low byte at even select
		if (data_wr.en) begin
			if (data_wr.sel[0]) begin
				st_next.data[data_wr.sel[2:1]][15:8] = data_wr.value;
			end else begin
				st_next.data[data_wr.sel[2:1]][7:0] = data_wr.value;
			end
		end
		// mode and arm in one write
		if (ctrl_wr.en) begin
			st_next.mode = ctrl_wr.mode;
		end
		if (flag_clear) begin
			st_next.wen = 1'b0;
		end
		case (st_reg.fsm)
			ST_IDLE: begin
				if (arm_request) begin
					st_next.arm = 1'b1;
					st_next.ticks = '0;
					st_next.fsm = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (timeout_hit) begin
					st_next.arm = 1'b0;
					st_next.fsm = ST_CHECK;
				end else if (slow_tick) begin
					st_next.ticks = st_reg.ticks + TICK_W'(1);
				end
			end
			ST_CHECK: begin
				// set on match, wins over clear
				if (pattern_match) begin
					st_next.wen = 1'b1;
				end
				st_next.fsm = ST_IDLE;
			end
			default: begin
				st_next.fsm = ST_IDLE;
				st_next.arm = 1'b0;
			end
		endcase
		// erase and write need the flag
		if (erase_req && st_reg.wen) begin
			st_next.erase_go = 1'b1;
			// page from high address and low bits 7..6
			st_next.page = {flash_addr_high,
				flash_addr_low[ADDR_LOW_PAGE_MSB:ADDR_LOW_PAGE_LSB]};
		end
		if (write_init_set && st_reg.wen) begin
			st_next.wt = 1'b1;
		end
		if (read_init_set) begin
			st_next.rd = 1'b1;
		end
		if (flash_done) begin
			st_next.wt = 1'b0;
			st_next.rd = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from state
	assign flash_mode_select = st_reg.mode;
	assign unlock_arm_bit = st_reg.arm;
	assign write_enabled_flag = st_reg.wen;
	assign write_initiate_bit = st_reg.wt;
	assign read_initiate_bit = st_reg.rd;
	assign cpu_halt = st_reg.wt || st_reg.rd;
	assign erase_go = st_reg.erase_go;
	assign erase_page = st_reg.page;
	assign data_words = st_reg.data;


	// output checks, one per guarded behaviour
	arm_start_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		arm_request && st_reg.fsm == ST_IDLE |=>
		unlock_arm_bit && flash_mode_select == MODE_WRITE_UNLOCK)
		else $error("arm request with unlock mode not accepted");
	mode_store_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ctrl_wr.en |=> flash_mode_select == $past(ctrl_wr.mode))
		else $error("mode select not stored");
	check_arm_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		st_reg.fsm == ST_CHECK |-> !unlock_arm_bit)
		else $error("pattern checked while still armed");
	window_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		unlock_arm_bit |-> st_reg.ticks < TICK_W'(TIMEOUT_TICKS))
		else $error("unlock window ran past its tick count");
	read_halt_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		read_init_set && !flash_done |=> read_initiate_bit && cpu_halt)
		else $error("processor not halted during read");
	erase_only_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!erase_req |=> !erase_go)
		else $error("erase started without a request");
	page_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!erase_go |-> $stable(erase_page))
		else $error("erase page changed without an erase");
	arm_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		st_reg.fsm == ST_ARMED && timeout_hit |=> !unlock_arm_bit ##1 st_reg.fsm == ST_IDLE)
		else $error("arm bit not cleared at timeout");
	armed_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(unlock_arm_bit) |-> unlock_arm_bit [*8])
		else $error("unlock window ended too early");
	flag_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		st_reg.fsm == ST_CHECK && pattern_match |=> write_enabled_flag)
		else $error("matching pattern did not enable writing");
	flag_stays_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		st_reg.fsm == ST_CHECK && !pattern_match && !write_enabled_flag |=> !write_enabled_flag)
		else $error("mismatch enabled writing");
	erase_block_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!write_enabled_flag |=> !erase_go && !$rose(write_initiate_bit))
		else $error("erase or write started while locked");
	flag_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		flag_clear && st_reg.fsm != ST_CHECK |=> !write_enabled_flag)
		else $error("flag clear not honoured");
	page_calc_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		erase_req && write_enabled_flag |=>
		erase_go && erase_page == {$past(flash_addr_high),
		$past(flash_addr_low[ADDR_LOW_PAGE_MSB:ADDR_LOW_PAGE_LSB])})
		else $error("erase page wrong");
	halt_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		write_initiate_bit && !flash_done |=> cpu_halt throughout write_initiate_bit [*1])
		else $error("processor not halted during write");
	wt_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		flash_done && write_initiate_bit |=> !write_initiate_bit && !cpu_halt)
		else $error("write initiate not cleared at completion");
endmodule // flash_write_unlock_sequencer

//--- flash_write_unlock_sequencer_test.sv
`timescale 1ns/1ns

module flash_write_unlock_sequencer_test;
	import flash_unlock_pkg::*;
	localparam int DIV = 4;
	localparam int TICKS = 3;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	ctrl_wr_s ctrl_wr = '0;
	data_wr_s data_wr = '0;
	logic flag_clear = 1'b0;
	logic write_init_set = 1'b0;
	logic read_init_set = 1'b0;
	logic erase_req = 1'b0;
	logic flash_done = 1'b0;
	logic [7:0] flash_addr_low = 8'h00;
	logic [5:0] flash_addr_high = 6'h00;
	logic [2:0] flash_mode_select;
	logic unlock_arm_bit, write_enabled_flag, write_initiate_bit, read_initiate_bit;
	logic cpu_halt, erase_go;
	logic [7:0] erase_page;
	logic [63:0] data_words;
	logic [7:0] pat [6] = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
	int failures = 0;
	int comparisons = 0;

	flash_write_unlock_sequencer #(.ADDR_HIGH_W(6), .OSC_DIV(DIV), .TIMEOUT_TICKS(TICKS))
		u_flash_write_unlock_sequencer (.ref_clk(ref_clk), .rst_b(rst_b), .ctrl_wr(ctrl_wr),
		.data_wr(data_wr), .flag_clear(flag_clear), .write_init_set(write_init_set),
		.read_init_set(read_init_set), .erase_req(erase_req), .flash_done(flash_done),
		.flash_addr_low(flash_addr_low), .flash_addr_high(flash_addr_high),
		.flash_mode_select(flash_mode_select), .unlock_arm_bit(unlock_arm_bit),
		.write_enabled_flag(write_enabled_flag), .write_initiate_bit(write_initiate_bit),
		.read_initiate_bit(read_initiate_bit), .cpu_halt(cpu_halt), .erase_go(erase_go),
		.erase_page(erase_page), .data_words(data_words));

	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;

	// compare and count
	task chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task finish_test();
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// inputs change on the falling edge only
	task cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// one control write: mode and arm together
	task ctrl(input logic [2:0] m, input logic a);
		ctrl_wr = '{1'b1, m, a};
		cyc(1);
		ctrl_wr.en = 1'b0;
	endtask

	// arm, enter the pattern with a chosen last byte, wait out the window
	task unlock(input logic [7:0] last);
		int n;
		ctrl(MODE_WRITE_UNLOCK, 1'b1);
		chk(unlock_arm_bit, 1);
		for (int i = 0; i < 6; i++) begin
			data_wr = '{1'b1, 3'(i + 2), (i == 5) ? last : pat[i]};
			cyc(1);
		end
		data_wr.en = 1'b0;
		n = 6;
		while (unlock_arm_bit === 1'b1 && n < 40) begin
			n++;
			cyc(1);
		end
		if (n >= 40) begin
			$display("CHECK FAILED at %0t: arm bit never cleared", $time);
			failures++;
			finish_test();
		end
		chk(n >= DIV * (TICKS - 1) + 1 && n <= DIV * TICKS, 1);
		chk(write_enabled_flag, 0);
		cyc(2);
	endtask

	initial begin
		cyc(4);
		rst_b = 1'b1;
		cyc(1);
		chk({flash_mode_select, unlock_arm_bit, write_enabled_flag, cpu_halt}, 0);
		// locked: erase and write requests do nothing
		erase_req = 1'b1;
		write_init_set = 1'b1;
		cyc(1);
		erase_req = 1'b0;
		write_init_set = 1'b0;
		chk({erase_go, write_initiate_bit}, 0);
		// other mode codes do not arm
		ctrl(3'h5, 1'b1);
		chk(unlock_arm_bit, 0);
		chk(flash_mode_select, 3'h5);
		cyc(1);
		// wrong last byte: flag stays low
		unlock(8'h41);
		chk(write_enabled_flag, 0);
		// correct pattern sets the flag
		unlock(8'h40);
		chk(write_enabled_flag, 1);
		chk(data_words[63:16], {PATTERN_WORD3, PATTERN_WORD2, PATTERN_WORD1});
		// page FE of the small variant (high 3F, low bits 7..6 = 10), low bits 5..0 ignored
		flash_addr_high = 6'h3F;
		flash_addr_low = 8'hBF;
		erase_req = 1'b1;
		cyc(1);
		erase_req = 1'b0;
		chk({erase_go, erase_page}, {1'b1, 8'hFE});
		cyc(1);
		chk(erase_go, 0);
		// write initiate halts until done
		write_init_set = 1'b1;
		cyc(1);
		write_init_set = 1'b0;
		chk({write_initiate_bit, cpu_halt}, 2'h3);
		cyc(3);
		flash_done = 1'b1;
		cyc(1);
		flash_done = 1'b0;
		chk({write_initiate_bit, cpu_halt}, 0);
		// software clear relocks erase and write
		flag_clear = 1'b1;
		cyc(1);
		flag_clear = 1'b0;
		chk(write_enabled_flag, 0);
		erase_req = 1'b1;
		write_init_set = 1'b1;
		read_init_set = 1'b1;
		cyc(1);
		erase_req = 1'b0;
		write_init_set = 1'b0;
		read_init_set = 1'b0;
		chk({erase_go, write_initiate_bit}, 0);
		chk({read_initiate_bit, cpu_halt}, 2'h3);
		flash_done = 1'b1;
		cyc(1);
		flash_done = 1'b0;
		chk(cpu_halt, 0);
		finish_test();
	end
endmodule // flash_write_unlock_sequencer_test
